/* File: src/iprc_top.v */
// What this block does
// - Clear, set, invert aliases at plus 4, 8, C
// - Control bit 12 selects multi-vector delivery
// - Threshold N admits group priority 1 to N
// - Threshold zero never starts proximity timer
// - Polarity bit one rising, zero falling edge
// - Unimplemented control bits read zero, ignore writes
// - All priority and control fields reset zero
// - Without USB its priority fields read zero
// - Trigger loads 32-bit reload into proximity timer
// - Vector and level meaningful in single-vector mode
// - Flag reads one once request occurred
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
`include "iprc_consts.vh"

module iprc_top #(
  parameter       HAS_USB      = 1,
  parameter [2:0] EXT_PRIORITY = 3'h1
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Avalon-MM slave
  input  wire [15:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // External interrupt pins
  input  wire [4:0]  ext_irq,
  // Peripheral request pulses
  input  wire [15:0] periph_req,
  // Core side
  output reg         cpu_request,
  output reg  [5:0]  cpu_vector,
  output reg  [2:0]  cpu_level,
  output reg         multi_vector,
  output reg         prox_active,
  output reg         irq
);

  localparam [31:0] PRIO7_MASK = HAS_USB ? `IPRC_PRIO_MASK : `IPRC_PRIO7_NOUSB;
  localparam        NSRC       = `IPRC_NUM_SRC;

  // Bus decode
  wire [15:0] base   = address & `IPRC_ALIAS_MASK;
  wire [1:0]  op     = address[`IPRC_OP_HI:`IPRC_OP_LO];
  wire        accept = (read | write) & ~waitrequest;
  wire        wr_acc = accept & write;
  wire [31:0] bmask;

  wire sel_p7   = (base == `IPRC_OFF_PRIO7);
  wire sel_p8   = (base == `IPRC_OFF_PRIO8);
  wire sel_p9   = (base == `IPRC_OFF_PRIO9);
  wire sel_p10  = (base == `IPRC_OFF_PRIO10);
  wire sel_ctrl = (base == `IPRC_OFF_CONTROL);
  wire sel_rld  = (base == `IPRC_OFF_RELOAD);
  wire sel_mask = (base == `IPRC_OFF_MASK);
  wire sel_flag = (address == `IPRC_OFF_FLAGS);
  // Read-only registers decode without aliases
  wire sel_stat = (address == `IPRC_OFF_STATUS);
  wire sel_cnt  = (address == `IPRC_OFF_COUNT);

  // Byte enables widened to bit masks
  genvar b;
  generate
    for (b = 0; b < `IPRC_NUM_LANES; b = b + 1) begin : g_lane
      assign bmask[b*`IPRC_LANE_BITS +: `IPRC_LANE_BITS] = {`IPRC_LANE_BITS{byteenable[b]}};
    end
  endgenerate

  wire [31:0] priority_group_seven;
  wire [31:0] priority_group_eight;
  wire [31:0] priority_group_nine;
  wire [31:0] priority_group_ten;
  wire [31:0] interrupt_control;
  wire [31:0] proximity_reload;
  wire [31:0] irq_mask;

  // Aliased registers
  iprc_alias_reg #(.MASK(PRIO7_MASK), .ALIAS(1)) u_prio7 (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_p7),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (priority_group_seven)
  );

  iprc_alias_reg #(.MASK(`IPRC_PRIO_MASK), .ALIAS(1)) u_prio8 (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_p8),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (priority_group_eight)
  );

  iprc_alias_reg #(.MASK(`IPRC_PRIO_MASK), .ALIAS(1)) u_prio9 (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_p9),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (priority_group_nine)
  );

  iprc_alias_reg #(.MASK(`IPRC_PRIO_MASK), .ALIAS(1)) u_prio10 (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_p10),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (priority_group_ten)
  );

  iprc_alias_reg #(.MASK(`IPRC_CTRL_MASK), .ALIAS(1)) u_ctrl (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_ctrl),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (interrupt_control)
  );

  iprc_alias_reg #(.MASK(32'hffffffff), .ALIAS(1)) u_reload (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_rld),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (proximity_reload)
  );

  iprc_alias_reg #(.MASK(`IPRC_FLAG_MASK), .ALIAS(1)) u_mask (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (wr_acc & sel_mask),
    .op    (op),
    .wdata (writedata),
    .bmask (bmask),
    .q     (irq_mask)
  );

  // Control fields
  wire       multi_vector_select = interrupt_control[`IPRC_CTRL_MULTI_VECTOR_SELECT];
  wire [2:0] proximity_threshold = interrupt_control[`IPRC_CTRL_THR_HI:`IPRC_CTRL_THR_LO];
  wire [4:0] ext_polarity        = interrupt_control[`IPRC_CTRL_POL_HI:`IPRC_CTRL_POL_LO];

  // External pin synchronisation and edge detection
  wire [4:0] ext_sync;
  reg  [4:0] ext_prev;

  iprc_sync #(.WIDTH(`IPRC_NUM_EXT)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   (ext_irq),
    .dout  (ext_sync)
  );

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_prev <= 5'h00;
    end else begin
      ext_prev <= ext_sync;
    end
  end

  wire [4:0] ext_rise = ext_sync & ~ext_prev;
  wire [4:0] ext_fall = ~ext_sync & ext_prev;
  wire [4:0] ext_evt  = (ext_rise & ext_polarity) | (ext_fall & ~ext_polarity);

  // Source levels: pri in 4:2, sub in 1:0
  wire [127:0] prio_all = {priority_group_ten, priority_group_nine, priority_group_eight, priority_group_seven};
  wire [NSRC*5-1:0] src_level;
  wire [15:0]       periph_ok = HAS_USB ? periph_req : (periph_req & ~(16'h0001 << `IPRC_USB_SRC));

  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_lvl
      if (g < `IPRC_NUM_EXT) begin : g_ext
        assign src_level[g*5 +: 5] = {EXT_PRIORITY, 2'h0};
      end else begin : g_per
        assign src_level[g*5 +: 5] = prio_all[(g-`IPRC_NUM_EXT)*`IPRC_SLOT_BITS +: 5];
      end
    end
  endgenerate

  // Request flags, set wins over clear
  reg  [NSRC-1:0] request_flags;
  wire [NSRC-1:0] src_evt    = {periph_ok, ext_evt};
  wire            flag_write = wr_acc & sel_flag;
  wire [NSRC-1:0] flag_clr   = flag_write ? (writedata[NSRC-1:0] & bmask[NSRC-1:0]) : {NSRC{1'b0}};
  wire [NSRC-1:0] next_flags = (request_flags & ~flag_clr) | src_evt;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      request_flags <= {NSRC{1'b0}};
    end else begin
      request_flags <= next_flags;
    end
  end

  // Proximity trigger: new event with priority 1..threshold
  reg trig;
  integer t;

  always @* begin
    trig = 1'b0;
    for (t = 0; t < NSRC; t = t + 1) begin
      if (src_evt[t] && src_level[t*5+`IPRC_PRI_LO +: 3] != 3'h0 &&
          src_level[t*5+`IPRC_PRI_LO +: 3] <= proximity_threshold) begin
        trig = 1'b1;
      end
    end
    if (proximity_threshold == 3'h0) begin
      trig = 1'b0;
    end
  end

  reg [31:0] prox_count;
  reg [31:0] next_count;
  reg        next_active;

  // Trigger reloads the count, otherwise it runs down to zero
  always @* begin
    next_count  = prox_count;
    next_active = 1'b0;
    if (trig) begin
      next_count  = proximity_reload;
      next_active = (proximity_reload != `IPRC_RESET_WORD);
    end else if (prox_count != `IPRC_RESET_WORD) begin
      next_count  = prox_count - 32'h00000001;
      next_active = (prox_count != 32'h00000001);
    end
  end

  // Count and active flag registers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prox_count  <= `IPRC_RESET_WORD;
      prox_active <= 1'b0;
    end else begin
      prox_count  <= next_count;
      prox_active <= next_active;
    end
  end

  // Arbitration over pending unmasked sources
  wire [20:0] pending = request_flags & irq_mask[20:0];
  reg         best_ok;
  reg  [4:0]  best_lvl;
  reg  [5:0]  best_idx;
  integer a;

  always @* begin
    best_ok  = 1'b0;
    best_lvl = 5'h00;
    best_idx = 6'h00;
    for (a = 0; a < NSRC; a = a + 1) begin
      if (pending[a] && src_level[a*5+`IPRC_PRI_LO +: 3] != 3'h0 &&
          (!best_ok || src_level[a*5 +: 5] > best_lvl)) begin
        best_ok  = 1'b1;
        best_lvl = src_level[a*5 +: 5];
        best_idx = a[5:0];
      end
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpu_request  <= 1'b0;
      cpu_vector   <= 6'h00;
      cpu_level    <= 3'h0;
      multi_vector <= 1'b0;
      irq          <= 1'b0;
    end else begin
      cpu_request  <= best_ok;
      cpu_vector   <= best_ok ? best_idx : 6'h00;
      cpu_level    <= best_ok ? best_lvl[`IPRC_PRI_HI:`IPRC_PRI_LO] : 3'h0;
      multi_vector <= multi_vector_select;
      irq          <= |pending;
    end
  end

  // Status shows vector and level only in single-vector mode
  wire [31:0] status_word = multi_vector ? 32'h00000000 :
                            {21'h000000, cpu_level, 2'h0, cpu_vector};

  // Read mux
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (sel_p7) begin
      rd_mux = priority_group_seven;
    end else if (sel_p8) begin
      rd_mux = priority_group_eight;
    end else if (sel_p9) begin
      rd_mux = priority_group_nine;
    end else if (sel_p10) begin
      rd_mux = priority_group_ten;
    end else if (sel_ctrl) begin
      rd_mux = interrupt_control;
    end else if (sel_rld) begin
      rd_mux = proximity_reload;
    end else if (sel_mask) begin
      rd_mux = irq_mask;
    end else if (sel_stat) begin
      rd_mux = status_word;
    end else if (sel_flag) begin
      rd_mux = {11'h000, request_flags};
    end else if (sel_cnt) begin
      rd_mux = prox_count;
    end
  end

  // One wait cycle, then accept with data
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      if ((read | write) && waitrequest) begin
        waitrequest <= 1'b0;
        readdata    <= read ? rd_mux : 32'h00000000;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

endmodule // iprc_top

/* File: common/iprc_consts.vh */
`ifndef IPRC_CONSTS_VH
`define IPRC_CONSTS_VH

// Register byte offsets
`define IPRC_OFF_PRIO7      16'h1100
`define IPRC_OFF_PRIO8      16'h1110
`define IPRC_OFF_PRIO9      16'h1120
`define IPRC_OFF_PRIO10     16'h1130
`define IPRC_OFF_CONTROL    16'h1000
`define IPRC_OFF_STATUS     16'h1010
`define IPRC_OFF_RELOAD     16'h1020
`define IPRC_OFF_FLAGS      16'h1030
`define IPRC_OFF_MASK       16'h1040
`define IPRC_OFF_COUNT      16'h1050

// Alias operations, address bits 3:2
`define IPRC_OP_WRITE       2'h0
`define IPRC_OP_CLR         2'h1
`define IPRC_OP_SET         2'h2
`define IPRC_OP_INV         2'h3
`define IPRC_ALIAS_MASK     16'hfff3
`define IPRC_OP_HI          3
`define IPRC_OP_LO          2

// Byte lanes of the data bus
`define IPRC_NUM_LANES      4
`define IPRC_LANE_BITS      8

// Implemented bits
`define IPRC_PRIO_MASK      32'h1f1f1f1f
`define IPRC_PRIO7_NOUSB    32'h1f001f1f
`define IPRC_CTRL_MASK      32'h0000171f
`define IPRC_FLAG_MASK      32'h001fffff

// Control fields
`define IPRC_CTRL_MULTI_VECTOR_SELECT      12
`define IPRC_CTRL_THR_HI    10
`define IPRC_CTRL_THR_LO    8
`define IPRC_CTRL_POL_HI    4
`define IPRC_CTRL_POL_LO    0

// Priority slot layout within a byte
`define IPRC_SLOT_BITS      8
`define IPRC_PRI_HI         4
`define IPRC_PRI_LO         2
`define IPRC_SUB_HI         1
`define IPRC_SUB_LO         0

// Status fields
`define IPRC_STAT_LVL_LO    8

// Source numbering
`define IPRC_NUM_EXT        5
`define IPRC_NUM_PERIPH     16
`define IPRC_NUM_SRC        21
`define IPRC_USB_SRC        2

// Reset values
`define IPRC_RESET_WORD     32'h00000000

`endif

/* File: src/iprc_sync.v */
`timescale 1ns/10ps
`include "iprc_consts.vh"

module iprc_sync #(
  parameter WIDTH = 5
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rstn,
  // Pins and synchronised copy
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta[i]   <= 1'b0;
          stable[i] <= 1'b0;
        end else begin
          meta[i]   <= din[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate

  assign dout = stable;

endmodule // iprc_sync

/* File: src/iprc_alias_reg.v */
`timescale 1ns/10ps
`include "iprc_consts.vh"

module iprc_alias_reg #(
  parameter [31:0] MASK  = 32'hffffffff,
  parameter        ALIAS = 1
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Write port
  input  wire        wr_en,
  input  wire [1:0]  op,
  input  wire [31:0] wdata,
  input  wire [31:0] bmask,
  // Stored value
  output reg  [31:0] q
);

  reg [31:0] next_q;
  reg [31:0] bits;

  always @* begin
    bits   = wdata & bmask;
    next_q = q;
    if (wr_en) begin
      case (ALIAS ? op : `IPRC_OP_WRITE)
        `IPRC_OP_CLR: next_q = q & ~bits;
        `IPRC_OP_SET: next_q = q | bits;
        `IPRC_OP_INV: next_q = q ^ bits;
        default:      next_q = (q & ~bmask) | bits;
      endcase
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= `IPRC_RESET_WORD;
    end else begin
      q <= next_q & MASK;
    end
  end

endmodule // iprc_alias_reg

/* File: bench/iprc_checker_sva.sv */
`timescale 1ns/10ps
module iprc_checker (
  // Clock and reset
  input wire        clock,
  input wire        rstn,
  // Bus
  input wire [15:0] address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Core side
  input wire        cpu_request,
  input wire [5:0]  cpu_vector,
  input wire [2:0]  cpu_level,
  input wire        multi_vector,
  input wire        prox_active,
  input wire        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire rd_ack = read && !waitrequest;
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  property p_multi_vector_select;
    write && !waitrequest && address == 16'h1000 && byteenable[1] |-> ##2 multi_vector == $past(writedata[12], 2);
  endproperty
  a_wait_answer: assert property (s_req |=> s_answer) else $error("bus answer not one wait cycle");
  a_multi_vector_select_follow: assert property (p_multi_vector_select) else $error("delivery mode does not follow control");
  a_ctrl_zero: assert property (rd_ack && address == 16'h1000 |-> (readdata & 32'hffffe8e0) == 32'h0)
    else $error("control unused bits not zero");
  a_prio_zero: assert property (rd_ack && address[15:6] == 10'h044 |-> (readdata & 32'he0e0e0e0) == 32'h0)
    else $error("priority unused bits not zero");
  a_unmapped_zero: assert property (rd_ack && address == 16'h2000 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(rstn) |-> !irq && !cpu_request && !prox_active && !multi_vector)
    else $error("outputs active after reset");
  a_req_level: assert property (cpu_request |-> cpu_level != 3'h0 && cpu_vector <= 6'h14)
    else $error("request without level");
  a_status_multi_vector_select: assert property (rd_ack && address == 16'h1010 && multi_vector |-> readdata == 32'h0)
    else $error("status not zero in multi vector");
endmodule // iprc_checker

bind iprc_top iprc_checker chk_i (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .cpu_request(cpu_request), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .multi_vector(multi_vector),
  .prox_active(prox_active), .irq(irq));

/* File: bench/iprc_core_model.sv */
`timescale 1ns/10ps
module iprc_core_model (
  // Clock and reset
  input  wire       clock,
  input  wire       rstn,
  // Request from controller
  input  wire       cpu_request,
  input  wire [5:0] cpu_vector,
  input  wire [2:0] cpu_level,
  // Last request taken
  output reg  [5:0] taken_vector,
  output reg  [2:0] taken_level
);
  // Core takes the presented vector while a request stands
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      taken_vector <= 6'h0;
      taken_level  <= 3'h0;
    end else if (cpu_request) begin
      taken_vector <= cpu_vector;
      taken_level  <= cpu_level;
    end
  end
endmodule // iprc_core_model

/* File: bench/test_interrupt_priority_and_control.sv */
`timescale 1ns/10ps
module test_interrupt_priority_and_control;
  logic        clock = 0;
  logic        rstn = 0;
  logic [15:0] address = 0;
  logic        read = 0;
  logic        write = 0;
  logic [31:0] writedata = 0;
  logic [3:0]  byteenable = 4'hf;
  logic [4:0]  ext_irq = 0;
  logic [15:0] periph_req = 0;
  wire  [31:0] readdata;
  wire         waitrequest, cpu_request, multi_vector, prox_active, irq;
  wire  [5:0]  cpu_vector, taken_vector;
  wire  [2:0]  cpu_level, taken_level;
  int          errors = 0;
  int          checks = 0;

  iprc_top #(.HAS_USB(0)) uut (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .ext_irq(ext_irq), .periph_req(periph_req), .cpu_request(cpu_request), .cpu_vector(cpu_vector),
    .cpu_level(cpu_level), .multi_vector(multi_vector), .prox_active(prox_active), .irq(irq));
  iprc_core_model core (.clock(clock), .rstn(rstn), .cpu_request(cpu_request), .cpu_vector(cpu_vector),
    .cpu_level(cpu_level), .taken_vector(taken_vector), .taken_level(taken_level));

  initial forever #2 clock = ~clock;

  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 40) begin
        errors++;
        tally_and_finish;
      end
      @(posedge clock);
    end
    q = readdata;
    write <= 0;
    read <= 0;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask

  task rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask

  task wait_irq(input logic v);
    int n;
    for (n = 0; n < 20 && irq !== v; n++) @(posedge clock);
    if (irq !== v) begin
      errors++;
      tally_and_finish;
    end
  endtask

  task t_regs;
    int i;
    rd_chk("control reset", 16'h1000, 32'h0);
    for (i = 0; i < 4; i++) rd_chk("priority reset", 16'h1100 + 16'(i * 16), 32'h0);
    wr(16'h1110, 32'hffffffff);
    rd_chk("priority fields", 16'h1110, 32'h1f1f1f1f);
    wr(16'h1114, 32'h0000001f);
    rd_chk("clear alias", 16'h1110, 32'h1f1f1f00);
    wr(16'h1118, 32'h00000003);
    rd_chk("set alias", 16'h1110, 32'h1f1f1f03);
    wr(16'h111c, 32'h0f0f0f0f);
    rd_chk("invert alias", 16'h1110, 32'h1010100c);
    wr(16'h1100, 32'hffffffff);
    rd_chk("usb slot", 16'h1100, 32'h1f001f1f);
    wr(16'h1000, 32'hffffffff);
    rd_chk("control bits", 16'h1000, 32'h0000171f);
    chk("multi vector on", 32'(multi_vector), 32'h1);
    wr(16'h1004, 32'hffffffff);
    rd_chk("control clear", 16'h1000, 32'h0);
    chk("multi vector off", 32'(multi_vector), 32'h0);
    rd_chk("unmapped", 16'h2000, 32'h0);
    $display("test registers done");
  endtask

  task t_ext;
    wr(16'h1040, 32'h001fffff);
    wr(16'h1000, 32'h00000001);
    @(posedge clock);
    ext_irq <= 5'h3;
    wait_irq(1);
    repeat (8) @(posedge clock);
    rd_chk("rising flags", 16'h1030, 32'h1);
    wr(16'h1030, 32'h1);
    wait_irq(0);
    ext_irq <= 5'h0;
    wait_irq(1);
    repeat (8) @(posedge clock);
    rd_chk("falling flags", 16'h1030, 32'h2);
    wr(16'h1030, 32'h2);
    wait_irq(0);
    $display("test external pins done");
  endtask

  task t_prox;
    logic [2:0] thr [4];
    logic       seen;
    int         i, n;
    thr = '{3'h2, 3'h3, 3'h7, 3'h0};
    wr(16'h1100, 32'h0000000c);
    wr(16'h1020, 32'h00000020);
    for (i = 0; i < 4; i++) begin
      wr(16'h1000, {21'h0, thr[i], 8'h0});
      wr(16'h1030, 32'h001fffff);
      @(posedge clock);
      periph_req <= 16'h1;
      @(posedge clock);
      periph_req <= 16'h0;
      seen = 0;
      for (n = 0; n < 12; n++) begin
        @(posedge clock);
        seen = seen | (prox_active === 1'b1);
      end
      chk("proximity start", 32'(seen), 32'(thr[i] != 0 && thr[i] >= 3));
      // Reload less the 13 edges between the trigger and the read sample
      rd_chk("proximity count", 16'h1050, (thr[i] >= 3) ? 32'h00000020 - 32'h0000000d : 32'h0);
      repeat (40) @(posedge clock);
      chk("proximity end", 32'(prox_active), 32'h0);
    end
    rd_chk("status single", 16'h1010, 32'h00000305);
    chk("core vector", {26'h0, taken_vector}, 32'h5);
    chk("core level", {29'h0, taken_level}, 32'h3);
    wr(16'h1000, 32'h00001000);
    repeat (2) @(posedge clock);
    rd_chk("status multi", 16'h1010, 32'h0);
    $display("test proximity done");
  endtask

  task t_reset;
    wr(16'h1120, 32'h1f1f1f1f);
    wr(16'h1000, 32'h0000171f);
    @(posedge clock);
    rstn <= 0;
    repeat (4) @(posedge clock);
    rstn <= 1;
    rd_chk("priority after reset", 16'h1120, 32'h0);
    rd_chk("control after reset", 16'h1000, 32'h0);
    chk("irq after reset", 32'(irq), 32'h0);
    $display("test reset done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1;
    t_regs;
    t_ext;
    t_prox;
    t_reset;
    tally_and_finish;
  end
endmodule // test_interrupt_priority_and_control
